//--- hdl/swed_pkg.sv
// Constants for the suspend wake event detector
package swed_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [4:0] A_LAN_CTRL = 5'h00;
   localparam logic [4:0] A_PWR_CTRL = 5'h04;
   localparam logic [4:0] A_PIN_CFG = 5'h08;
   localparam logic [4:0] A_LED_CFG = 5'h0c;
   localparam logic [4:0] A_PIN_WAKE = 5'h10;
   localparam logic [4:0] A_IRQ_STS = 5'h14;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int NPIN = 11;
   localparam int LC_SEEN_LSB = 5;
   localparam int PC_LAN_EN = 2;
   localparam int PC_ENERGY_WAKE_EN = 3;
   localparam int PC_WSB_LSB = 4;
   localparam int PC_SUSP = 8;
   localparam int LED_DIR_LSB = 8;
   localparam int PW_POL_LSB = 16;
   localparam int PW_LINK_SEL = 31;
   localparam int GATED_PINS = 8;
   localparam int LINK_PIN = 7;
   // ----------------------------------------
   // Reset values and masks
   // ----------------------------------------
   localparam logic [4:0] EN_FULL_MASK = 5'h1f;
   localparam logic [4:0] EN_RED_MASK = 5'h07;
   localparam logic [7:0] GATE_RST = 8'hff;
   localparam logic [5:0] FSEL_RST = 6'h15;
   localparam logic [2:0] PDIR_RST = 3'h7;
   localparam logic [1:0] FSEL_GPIO = 2'h0;
   // ----------------------------------------
   // Suspend mode codes
   // ----------------------------------------
   localparam logic [1:0] M_SLEEP_WOL = 2'h0;
   localparam logic [1:0] M_SLEEP_ENERGY = 2'h1;
   localparam logic [1:0] M_SLEEP_DEEP = 2'h2;
   localparam logic [1:0] M_SLEEP_GOODFRAME = 2'h3;
   typedef enum logic {SWED_NORMAL, SWED_SUSPENDED} swed_st_t;
endpackage : swed_pkg

//--- hdl/swed_top.sv
// Suspend wake event detector with register port
`timescale 1ns/1ps
`default_nettype none
module swed_top
   import swed_pkg::*;
#(
   parameter bit FULL_VARIANT = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic unicast_hit,
   input wire logic magic_hit,
   input wire logic pattern_hit,
   input wire logic exact_hit,
   input wire logic broadcast_hit,
   input wire logic good_frame,
   input wire logic phy_irq,
   input wire logic phy_link_up,
   input wire logic [NPIN-1:0] gpio_pin,
   input wire logic ext_phy_pin,
   input wire logic usb_suspend,
   output logic remote_wake,
   output logic wake_irq,
   output logic suspended
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      swed_st_t st;
      logic [4:0] lan_en;
      logic [3:0] seen;
      logic [1:0] mode;
      logic lan_wake_en;
      logic energy_wake_en;
      logic [1:0] wsb;
      logic [7:0] gate;
      logic [5:0] fsel;
      logic [2:0] pdir;
      logic [NPIN-1:0] pin_en;
      logic [NPIN-1:0] pin_pol;
      logic link_sel;
      logic [NPIN-1:0] pin_irq;
      logic [NPIN-1:0] g1;
      logic [NPIN-1:0] g2;
      logic x1;
      logic x2;
      logic susp_q;
      logic [31:0] rdata;
      logic rwake;
      logic wirq;
   } swed_state_t;

   swed_state_t s;
   swed_state_t next_s;

   function automatic logic mode_is(input logic [1:0] m, input logic [1:0] code);
      mode_is = (m == code);
   endfunction : mode_is

   logic [4:0] en_mask;
   logic [4:0] hits;
   logic [4:0] en_eff;
   logic composite;
   logic all_clear;
   logic gf;
   logic mac_evt;
   logic lan_set;
   logic ed_set;
   logic [3:0] seen_set;
   logic [NPIN-1:0] pin_lvl;
   logic [NPIN-1:0] pin_cap;
   logic [NPIN-1:0] pin_hit;
   logic link_mode;
   logic lan_req;
   logic ed_req;
   logic gp_req;
   logic wake_req;
   logic wr_lan;
   logic wr_pwr;
   logic wr_irq;

   // ----------------------------------------
   // LAN and energy sources
   // ----------------------------------------
   // full or reduced enable set, chosen by FULL_VARIANT
   assign en_mask = FULL_VARIANT ? EN_FULL_MASK : EN_RED_MASK;
   assign hits = {broadcast_hit, exact_hit, pattern_hit, magic_hit, unicast_hit};
   assign en_eff = s.lan_en & en_mask;
   assign composite = |(en_eff & hits);
   assign all_clear = (en_eff == 5'h00);
   assign gf = FULL_VARIANT && all_clear && good_frame;
   assign mac_evt = composite | gf;
   assign lan_set = (composite & s.lan_wake_en) | gf;
   assign ed_set = phy_irq & s.energy_wake_en;
   assign seen_set = {broadcast_hit & en_eff[4], exact_hit & en_eff[3],
                      magic_hit & en_eff[1], pattern_hit & en_eff[2]};

   // ----------------------------------------
   // GPIO wake detection
   // ----------------------------------------
   assign link_mode = FULL_VARIANT && s.link_sel;
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         assign pin_lvl[gi] = s.pin_pol[gi] ? s.g2[gi] : ~s.g2[gi];
         if (gi < GATED_PINS) begin : g_low
            assign pin_cap[gi] = ~s.gate[gi] & ~s.x2;
         end else begin : g_high
            assign pin_cap[gi] = (s.fsel[2*(gi-GATED_PINS) +: 2] == FSEL_GPIO)
                                 & ~s.pdir[gi-GATED_PINS];
         end
         if (gi == LINK_PIN) begin : g_link
            assign pin_hit[gi] = link_mode ?
               (s.pin_en[gi] & pin_cap[gi] & phy_link_up &
                (mode_is(s.mode, M_SLEEP_WOL) | mode_is(s.mode, M_SLEEP_GOODFRAME))) :
               (s.pin_en[gi] & pin_cap[gi] & pin_lvl[gi]);
         end else begin : g_plain
            assign pin_hit[gi] = s.pin_en[gi] & pin_cap[gi] & pin_lvl[gi];
         end
      end
   endgenerate

   // ----------------------------------------
   // Wake requests from sticky status
   // ----------------------------------------
   // WOL only in sleep_wol, good frame only in goodframe
   assign lan_req = s.wsb[1] & ((s.lan_wake_en & mode_is(s.mode, M_SLEEP_WOL)) |
                    (FULL_VARIANT & all_clear & mode_is(s.mode, M_SLEEP_GOODFRAME)));
   assign ed_req = s.wsb[0] & s.energy_wake_en & mode_is(s.mode, M_SLEEP_ENERGY);
   assign gp_req = |s.pin_irq;
   assign wake_req = lan_req | ed_req | gp_req;

   assign wr_lan = reg_wr && (reg_addr == A_LAN_CTRL);
   assign wr_pwr = reg_wr && (reg_addr == A_PWR_CTRL);
   assign wr_irq = reg_wr && (reg_addr == A_IRQ_STS);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_s = s;
      // Pins are asynchronous, two stages first
      next_s.g1 = gpio_pin;
      next_s.g2 = s.g1;
      next_s.x1 = ext_phy_pin;
      next_s.x2 = s.x1;
      next_s.susp_q = usb_suspend;
      next_s.rwake = 1'b0;
      next_s.rdata = 32'h0000_0000;
      next_s.wirq = lan_set | ed_set;
      if (reg_rd) begin
         unique case (reg_addr)
            A_LAN_CTRL: next_s.rdata = {23'h0, s.seen, en_eff};
            A_PWR_CTRL: next_s.rdata = {23'h0, (s.st == SWED_SUSPENDED), 2'h0,
                                        s.wsb, s.energy_wake_en, s.lan_wake_en, s.mode};
            A_PIN_CFG: next_s.rdata = {24'h0, s.gate};
            A_LED_CFG: next_s.rdata = {21'h0, s.pdir, 2'h0, s.fsel};
            A_PIN_WAKE: next_s.rdata = {s.link_sel, 4'h0, s.pin_pol, 5'h00, s.pin_en};
            A_IRQ_STS: next_s.rdata = {21'h0, s.pin_irq};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_lan) begin
         next_s.lan_en = reg_wdata[4:0] & en_mask;
      end
      if (wr_pwr) begin
         next_s.mode = reg_wdata[1:0];
         next_s.lan_wake_en = reg_wdata[PC_LAN_EN];
         next_s.energy_wake_en = reg_wdata[PC_ENERGY_WAKE_EN];
      end
      if (reg_wr && (reg_addr == A_PIN_CFG)) begin
         next_s.gate = reg_wdata[7:0];
      end
      if (reg_wr && (reg_addr == A_LED_CFG)) begin
         next_s.fsel = reg_wdata[5:0];
         next_s.pdir = reg_wdata[LED_DIR_LSB +: 3];
      end
      if (reg_wr && (reg_addr == A_PIN_WAKE)) begin
         next_s.pin_en = reg_wdata[NPIN-1:0];
         next_s.pin_pol = reg_wdata[PW_POL_LSB +: NPIN];
         next_s.link_sel = reg_wdata[PW_LINK_SEL];
      end
      // Write one to clear; a new event in the same cycle wins
      // seen flags
      next_s.seen = seen_set |
         (s.seen & ~(wr_lan ? reg_wdata[LC_SEEN_LSB +: 4] : 4'h0));
      // status set, LAN held while MAC event, energy held while PHY irq
      next_s.wsb[1] = lan_set |
         (s.wsb[1] & ~(wr_pwr & reg_wdata[PC_WSB_LSB+1] & ~mac_evt));
      next_s.wsb[0] = ed_set |
         (s.wsb[0] & ~(wr_pwr & reg_wdata[PC_WSB_LSB] & ~phy_irq));
      next_s.pin_irq = pin_hit |
         (s.pin_irq & ~(wr_irq ? reg_wdata[NPIN-1:0] : {NPIN{1'b0}}));
      unique case (s.st)
         SWED_NORMAL: begin
            if (usb_suspend && !s.susp_q) begin
               next_s.st = SWED_SUSPENDED;
            end
         end
         SWED_SUSPENDED: begin
            if (wake_req) begin
               next_s.rwake = 1'b1;
               next_s.st = SWED_NORMAL;
            end else if (!usb_suspend) begin
               next_s.st = SWED_NORMAL;
            end
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s <= '0;
         s.st <= SWED_NORMAL;
         s.mode <= M_SLEEP_DEEP;
         s.gate <= GATE_RST;
         s.fsel <= FSEL_RST;
         s.pdir <= PDIR_RST;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign remote_wake = s.rwake;
   assign wake_irq = s.wirq;
   assign suspended = (s.st == SWED_SUSPENDED);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence susp_with_req;
      suspended && wake_req;
   endsequence
   sequence one_wake_pulse;
      remote_wake && !suspended ##1 !remote_wake;
   endsequence

   lan_irq_a: assert property (
      composite && s.lan_wake_en |=> wake_irq && s.wsb[1])
      else $error("LAN event did not raise wake");
   reduced_en_a: assert property (
      FULL_VARIANT || (s.lan_en[4:3] == 2'h0 && s.seen[3:2] == 2'h0))
      else $error("Reduced variant holds absent enables");
   energy_hold_a: assert property (
      s.wsb[0] && phy_irq |=> s.wsb[0])
      else $error("Energy status cleared during PHY irq");
   lan_hold_a: assert property (
      s.wsb[1] && mac_evt |=> s.wsb[1])
      else $error("LAN status cleared during MAC event");
   magic_flag_a: assert property (
      magic_hit && en_eff[1] |=> s.seen[1])
      else $error("Magic flag not set");
   good_frame_a: assert property (
      gf |=> wake_irq ##0 s.wsb[1])
      else $error("Good frame lost");
   pin_flag_a: assert property (
      pin_hit != 0 |=> (s.pin_irq & $past(pin_hit)) == $past(pin_hit))
      else $error("Pin flag not set");
   wake_seq_a: assert property (
      susp_with_req |=> one_wake_pulse)
      else $error("Wake sequence wrong");
   wol_only_a: assert property (
      suspended && !gp_req && !ed_req && s.wsb[1] && s.lan_wake_en
      && !all_clear && !mode_is(s.mode, M_SLEEP_WOL) |=> !remote_wake)
      else $error("LAN wake outside sleep_wol");
   ext_phy_a: assert property (
      s.x2 |-> pin_hit[GATED_PINS-1:0] == 8'h00)
      else $error("Low pin woke in external PHY mode");
   link_ignore_a: assert property (
      link_mode && mode_is(s.mode, M_SLEEP_DEEP) |-> !pin_hit[LINK_PIN])
      else $error("Pin level used under link-up select");
endmodule : swed_top
`default_nettype wire

//--- tb/swed_host_model.sv
// Host side model: suspend signalling and remote wake counting
`timescale 1ns/1ps
`default_nettype none
module swed_host_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sleep_req,
   input wire logic remote_wake,
   output logic usb_suspend,
   output logic [15:0] wake_cnt
);
   logic woke;
   // ----------------------------------------
   // Suspend and resume
   // ----------------------------------------
   // Suspend, resume on wake
   // Resume held until the bench drops its request, so no second rising edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         usb_suspend <= 1'b0;
         woke <= 1'b0;
         wake_cnt <= 16'h0;
      end else begin
         if (remote_wake) begin
            wake_cnt <= wake_cnt + 16'h1;
         end
         woke <= sleep_req & (woke | remote_wake);
         usb_suspend <= sleep_req & ~woke & ~remote_wake;
      end
   end
endmodule : swed_host_model
`default_nettype wire

//--- tb/swed_top_tb_top.sv
// Bench for the suspend wake event detector
`timescale 1ns/1ps
`default_nettype none
module swed_top_tb_top;
   import swed_pkg::*;
   logic clk, sys_rst, reg_wr, reg_rd, unicast_hit, magic_hit, pattern_hit;
   logic exact_hit, broadcast_hit, good_frame, phy_irq, phy_link_up, ext_phy_pin;
   logic sleep_req, usb_suspend, remote_wake, wake_irq, suspended;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [NPIN-1:0] gpio_pin;
   logic [15:0] wake_cnt, base;
   int fails, check_count, cycles;
   swed_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .unicast_hit(unicast_hit),
      .magic_hit(magic_hit), .pattern_hit(pattern_hit), .exact_hit(exact_hit),
      .broadcast_hit(broadcast_hit), .good_frame(good_frame), .phy_irq(phy_irq),
      .phy_link_up(phy_link_up), .gpio_pin(gpio_pin), .ext_phy_pin(ext_phy_pin),
      .usb_suspend(usb_suspend), .remote_wake(remote_wake), .wake_irq(wake_irq),
      .suspended(suspended));
   swed_host_model host (.clk(clk), .sys_rst(sys_rst), .sleep_req(sleep_req),
      .remote_wake(remote_wake), .usb_suspend(usb_suspend), .wake_cnt(wake_cnt));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check_val(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check_val
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      // Sampled at the edge that ends the data cycle, so callers stay edge aligned
      @(posedge clk);
      check_val($sformatf("reg %h", a), reg_rdata, exp);
   endtask : rd
   task automatic sleep();
      @(posedge clk);
      sleep_req <= 1'b0;
      @(posedge clk);
      base = wake_cnt;
      sleep_req <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : sleep
   // Fixed window covers the pin synchroniser and the pulse path
   task automatic wait_wake(input logic exp);
      logic got;
      got = 1'b0;
      repeat (20) begin
         @(posedge clk);
         if (wake_cnt !== base) got = 1'b1;
      end
      check_val("remote wake", {31'h0, got}, {31'h0, exp});
   endtask : wait_wake
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {reg_wr, reg_rd, unicast_hit, magic_hit, pattern_hit, exact_hit} = '0;
      {broadcast_hit, good_frame, phy_irq, phy_link_up, ext_phy_pin, sleep_req} = '0;
      sys_rst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      gpio_pin = '0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd(A_LAN_CTRL, 32'h0);
      rd(A_PWR_CTRL, 32'h2);
      rd(A_PIN_CFG, 32'hff);
      rd(A_LED_CFG, 32'h715);
      rd(A_PIN_WAKE, 32'h0);
      rd(A_IRQ_STS, 32'h0);
      rd(5'h18, 32'h0);
      $display("test reset done");
      wr(A_LAN_CTRL, 32'h2);
      wr(A_PWR_CTRL, 32'h4);
      sleep();
      check_val("suspended", {31'h0, suspended}, 32'h1);
      @(posedge clk);
      magic_hit <= 1'b1;
      @(posedge clk);
      magic_hit <= 1'b0;
      wait_wake(1'b1);
      check_val("suspended", {31'h0, suspended}, 32'h0);
      rd(A_PWR_CTRL, 32'h24);
      rd(A_LAN_CTRL, 32'h42);
      wr(A_LAN_CTRL, 32'h1e2);
      wr(A_PWR_CTRL, 32'h36);
      sleep();
      @(posedge clk);
      magic_hit <= 1'b1;
      @(posedge clk);
      magic_hit <= 1'b0;
      wait_wake(1'b0);
      rd(A_PWR_CTRL, 32'h126);
      wr(A_PWR_CTRL, 32'h4);
      wait_wake(1'b1);
      wr(A_LAN_CTRL, 32'h1e0);
      wr(A_PWR_CTRL, 32'h32);
      // Hits gated by enables, flags set outside suspend too
      wr(A_LAN_CTRL, 32'h1c);
      @(posedge clk);
      {unicast_hit, pattern_hit, exact_hit, broadcast_hit} <= 4'hf;
      @(posedge clk);
      {unicast_hit, pattern_hit, exact_hit, broadcast_hit} <= 4'h0;
      rd(A_LAN_CTRL, 32'h1bc);
      rd(A_PWR_CTRL, 32'h2);
      wr(A_LAN_CTRL, 32'h1e0);
      $display("test lan done");
      phy_irq <= 1'b1;
      wr(A_PWR_CTRL, 32'h9);
      @(posedge clk);
      #1;
      check_val("wake irq", {31'h0, wake_irq}, 32'h1);
      wr(A_PWR_CTRL, 32'h19);
      rd(A_PWR_CTRL, 32'h19);
      phy_irq <= 1'b0;
      wr(A_PWR_CTRL, 32'h19);
      rd(A_PWR_CTRL, 32'h9);
      sleep();
      @(posedge clk);
      phy_irq <= 1'b1;
      @(posedge clk);
      phy_irq <= 1'b0;
      wait_wake(1'b1);
      wr(A_PWR_CTRL, 32'h32);
      $display("test energy done");
      wr(A_PIN_WAKE, 32'h0208_0208);
      ext_phy_pin <= 1'b1;
      gpio_pin <= 11'h208;
      sleep();
      wait_wake(1'b0);
      wr(A_PIN_CFG, 32'hf7);
      wait_wake(1'b0);
      rd(A_IRQ_STS, 32'h0);
      wr(A_LED_CFG, 32'h511);
      wait_wake(1'b1);
      rd(A_IRQ_STS, 32'h200);
      gpio_pin <= 11'h0;
      ext_phy_pin <= 1'b0;
      // Let the synchroniser drain, else the set beats the clear
      repeat (3) @(posedge clk);
      wr(A_IRQ_STS, 32'h7ff);
      $display("test pin done");
      wr(A_PWR_CTRL, 32'h0);
      wr(A_PIN_WAKE, 32'h8080_0080);
      wr(A_PIN_CFG, 32'h7f);
      gpio_pin <= 11'h080;
      sleep();
      wait_wake(1'b0);
      rd(A_IRQ_STS, 32'h0);
      wr(A_PWR_CTRL, 32'h2);
      phy_link_up <= 1'b1;
      wait_wake(1'b0);
      wr(A_PWR_CTRL, 32'h0);
      wait_wake(1'b1);
      rd(A_IRQ_STS, 32'h80);
      phy_link_up <= 1'b0;
      gpio_pin <= 11'h0;
      wr(A_IRQ_STS, 32'h7ff);
      $display("test link done");
      wr(A_PWR_CTRL, 32'h3);
      sleep();
      @(posedge clk);
      good_frame <= 1'b1;
      @(posedge clk);
      good_frame <= 1'b0;
      wait_wake(1'b1);
      rd(A_PWR_CTRL, 32'h23);
      sleep();
      wait_wake(1'b1);
      $display("test frame done");
      report_and_stop();
   end
endmodule : swed_top_tb_top
`default_nettype wire
